// ### amigr_pkg.sv
/*
 * Constants, state type and helper functions for the audio mixer input
 * gain register bank. Assumes one 100 MHz clock and a synchronous reset.
 */
// Notes on behaviour
// - Mixer gain fields: 5 bits, 1.5 dB steps
// - Mixer code 00h +12 dB, 1Fh -34.5, reset 0Ch
// - Bit 7 mutes the channel path output
// - Mute 1 means muted; every mute resets set
// - Capture gain fields: 4 bits, 1.5 dB steps
// - Capture code 0h unity, Fh +22.5; reset 0h
// - Capture mute silences gain stage, stream continues
// - Separate left/right registers, each own channel only
// - Host page 1 address; controller uses A1 prefix
package amigr_pkg;

	localparam int        NREG        = 9;     // Registers in the bank
	localparam int        NMIX        = 7;     // Mixer input registers
	localparam int        MUTE_BIT    = 7;     // Mute position
	localparam int        MIX_W       = 5;     // Mixer gain field width
	localparam int        CAP_W       = 4;     // Capture gain field width
	localparam logic       HOST_PAGE   = 1'b1;  // Host register page
	localparam logic [7:0] UC_PREFIX   = 8'hA1; // Controller high byte
	// Offsets, lowest first; index = offset - OFF_DAC0R
	localparam logic [7:0] OFF_DAC0R   = 8'hA9;
	localparam logic [7:0] OFF_DAC1L   = 8'hAA;
	localparam logic [7:0] OFF_DAC1R   = 8'hAB;
	localparam logic [7:0] OFF_LINEL   = 8'hAC;
	localparam logic [7:0] OFF_LINER   = 8'hAD;
	localparam logic [7:0] OFF_AMICL   = 8'hAE;
	localparam logic [7:0] OFF_AMICR   = 8'hAF;
	localparam logic [7:0] OFF_CAP0L   = 8'hB0;
	localparam logic [7:0] OFF_CAP0R   = 8'hB1;
	localparam logic [3:0] IDX_NONE    = 4'hF;  // Unmapped offset
	// Reset values: mute set, mixer code 0Ch, capture code 0h
	localparam logic [7:0] MIX_RST     = 8'h8C;
	localparam logic [7:0] CAP_RST     = 8'h80;
	localparam logic [7:0] UNMAPPED_RD = 8'h00; // Read of a hole
	// Gain decode in half-dB units
	localparam int        MIX_TOP_HDB = 24;    // Code 0: +12 dB
	localparam int        STEP_HDB    = 3;     // 1.5 dB per code

	// Whole bank state, registered as one
	typedef struct packed {
		logic [NREG-1:0][7:0] regs;   // Stored register bytes
		logic [NMIX-1:0][7:0] mixg;   // Mixer gain, signed half-dB
		logic [1:0][5:0]      capg;   // Capture gain, half-dB
		logic [7:0]           host_rd; // Host read data
		logic [7:0]           uc_rd;   // Controller read data
	} amigr_state_s;

	// Offset to register index, IDX_NONE when unmapped
	function automatic logic [3:0] amigr_idx(input logic [7:0] off);
		logic [7:0] d;
		d = off - OFF_DAC0R;
		if (off >= OFF_DAC0R && off <= OFF_CAP0R) begin
			amigr_idx = d[3:0];
		end else begin
			amigr_idx = IDX_NONE;
		end
	endfunction

	// Mixer code to signed half-dB: +24 down to -69
	function automatic logic [7:0] amigr_mix_hdb(
		input logic [MIX_W-1:0] code);
		amigr_mix_hdb = 8'(MIX_TOP_HDB - STEP_HDB * int'(code));
	endfunction

	// Capture code to half-dB: 0 up to 45
	function automatic logic [5:0] amigr_cap_hdb(
		input logic [CAP_W-1:0] code);
		amigr_cap_hdb = 6'(STEP_HDB * int'(code));
	endfunction

	// Reset byte for a register index
	function automatic logic [7:0] amigr_rst(input int i);
		amigr_rst = (i < NMIX) ? MIX_RST : CAP_RST;
	endfunction

endpackage

// ### amigr_regs.sv
/*
 * Audio mixer input gain register bank. Nine 8-bit read/write registers,
 * reached by the I2C slave on register page 1 and by the embedded
 * controller at A1xxh. Assumes both access ports are driven by logic on
 * mclk_i, with strobes one cycle wide, so no synchroniser is needed.
 */
`timescale 1ns/1ps
module amigr_regs (
	input  wire logic                        mclk_i,
	input  wire logic                        resetn_i,
	// Host side, behind the I2C slave
	input  wire logic                        host_page_i,
	input  wire logic [7:0]                  host_addr_i,
	input  wire logic                        host_wr_i,
	input  wire logic                        host_rd_i,
	input  wire logic [7:0]                  host_wdata_i,
	output logic      [7:0]                  host_rdata_o,
	// Embedded controller side
	input  wire logic [15:0]                 uc_addr_i,
	input  wire logic                        uc_wr_i,
	input  wire logic                        uc_rd_i,
	input  wire logic [7:0]                  uc_wdata_i,
	output logic      [7:0]                  uc_rdata_o,
	// Gain fields towards the analog mixer
	output logic      [amigr_pkg::MIX_W-1:0] dac0_right_mix_level_o,
	output logic      [amigr_pkg::MIX_W-1:0] dac1_left_mix_level_o,
	output logic      [amigr_pkg::MIX_W-1:0] dac1_right_mix_level_o,
	output logic      [amigr_pkg::MIX_W-1:0] line_left_mix_level_o,
	output logic      [amigr_pkg::MIX_W-1:0] line_right_mix_level_o,
	output logic      [amigr_pkg::MIX_W-1:0] amic_left_mix_level_o,
	output logic      [amigr_pkg::MIX_W-1:0] amic_right_mix_level_o,
	output logic      [amigr_pkg::CAP_W-1:0] capture0_left_gain_level_o,
	output logic      [amigr_pkg::CAP_W-1:0] capture0_right_gain_level_o,
	// Mute per path, 1 = silent
	output logic      [amigr_pkg::NREG-1:0]  path_mute_o,
	// Decoded gains in half-dB steps
	output logic      [amigr_pkg::NMIX-1:0][7:0] mix_gain_hdb_o,
	output logic      [1:0][5:0]             capture0_gain_hdb_o
);
	import amigr_pkg::*;

	amigr_state_s state_reg;  // All state
	amigr_state_s state_next; // Its next value
	logic         host_hit;   // Host access on our page
	logic         uc_hit;     // Controller access in our block
	logic [3:0]   host_idx;   // Host register index
	logic [3:0]   uc_idx;     // Controller register index

	// Address decode, shared by reads and writes
	always_comb begin
		host_hit = (host_page_i == HOST_PAGE);
		uc_hit   = (uc_addr_i[15:8] == UC_PREFIX);
		host_idx = host_hit ? amigr_idx(host_addr_i) : IDX_NONE;
		uc_idx   = uc_hit ? amigr_idx(uc_addr_i[7:0]) : IDX_NONE;
	end

	// Next state: writes, decode, read capture
	always_comb begin
		state_next = state_reg;
		if (!resetn_i) begin
			// Every path muted, gains at their defaults
			for (int i = 0; i < NREG; i++) begin
				state_next.regs[i] = amigr_rst(i);
			end
			state_next.host_rd = 8'h00;
			state_next.uc_rd   = 8'h00;
		end else begin
			// Controller first so a same-register host write wins
			if (uc_wr_i && uc_idx != IDX_NONE) begin
				state_next.regs[uc_idx] = uc_wdata_i;
			end
			// Whole byte stored, reserved bits included
			if (host_wr_i && host_idx != IDX_NONE) begin
				state_next.regs[host_idx] = host_wdata_i;
			end
			// Read data is the stored byte, holes give zero
			if (host_rd_i) begin
				state_next.host_rd = (host_idx != IDX_NONE) ?
					state_reg.regs[host_idx] : UNMAPPED_RD;
			end
			if (uc_rd_i) begin
				state_next.uc_rd = (uc_idx != IDX_NONE) ?
					state_reg.regs[uc_idx] : UNMAPPED_RD;
			end
		end
		// Gains follow the stored fields in the same cycle
		for (int i = 0; i < NMIX; i++) begin
			state_next.mixg[i] =
				amigr_mix_hdb(state_next.regs[i][MIX_W-1:0]);
		end
		for (int i = 0; i < 2; i++) begin
			state_next.capg[i] =
				amigr_cap_hdb(state_next.regs[NMIX+i][CAP_W-1:0]);
		end
	end

	// Single state register
	always_ff @(posedge mclk_i) begin
		state_reg <= state_next;
	end

	// Fields straight from the stored bytes
	always_comb begin
		dac0_right_mix_level_o      = state_reg.regs[0][MIX_W-1:0];
		dac1_left_mix_level_o       = state_reg.regs[1][MIX_W-1:0];
		dac1_right_mix_level_o      = state_reg.regs[2][MIX_W-1:0];
		line_left_mix_level_o       = state_reg.regs[3][MIX_W-1:0];
		line_right_mix_level_o      = state_reg.regs[4][MIX_W-1:0];
		amic_left_mix_level_o       = state_reg.regs[5][MIX_W-1:0];
		amic_right_mix_level_o      = state_reg.regs[6][MIX_W-1:0];
		capture0_left_gain_level_o  = state_reg.regs[7][CAP_W-1:0];
		capture0_right_gain_level_o = state_reg.regs[8][CAP_W-1:0];
		host_rdata_o                = state_reg.host_rd;
		uc_rdata_o                  = state_reg.uc_rd;
		mix_gain_hdb_o              = state_reg.mixg;
		capture0_gain_hdb_o         = state_reg.capg;
		// Capture mutes gate only the gain stage; the converter never
		// sees them, so its sample stream keeps running
		for (int i = 0; i < NREG; i++) begin
			path_mute_o[i] = state_reg.regs[i][MUTE_BIT];
		end
	end

	// Checks on the bank
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	AST_MIX_RESET: assert property (
		$rose(resetn_i) |-> line_left_mix_level_o == 5'h0C &&
			dac0_right_mix_level_o == 5'h0C)
		else $error("mixer gain not at 0Ch after reset");

	AST_MUTE_RESET: assert property (
		$rose(resetn_i) |-> path_mute_o == 9'h1FF)
		else $error("paths not muted after reset");

	AST_CAP_RESET: assert property (
		$rose(resetn_i) |-> capture0_left_gain_level_o == 4'h0 &&
			capture0_gain_hdb_o[1] == 6'h00)
		else $error("capture gain not zero after reset");

	AST_MIX_DECODE: assert property (
		##1 mix_gain_hdb_o[3] ==
			8'(24 - 3 * int'(line_left_mix_level_o)))
		else $error("mixer gain decode wrong");

	AST_CAP_DECODE: assert property (
		##1 capture0_gain_hdb_o[0] ==
			6'(3 * int'(capture0_left_gain_level_o)))
		else $error("capture gain decode wrong");

	AST_HOST_WRITE: assert property (
		host_wr_i && host_page_i && host_addr_i == 8'hAC
		|=> line_left_mix_level_o == $past(host_wdata_i[4:0]) &&
			path_mute_o[3] == $past(host_wdata_i[7]))
		else $error("host write to AC not stored");

	AST_UC_WRITE: assert property (
		uc_wr_i && uc_addr_i == 16'hA1B1 &&
		!(host_wr_i && host_page_i && host_addr_i == 8'hB1)
		|=> capture0_right_gain_level_o == $past(uc_wdata_i[3:0]))
		else $error("controller write to A1B1 not stored");

	AST_OWN_CHANNEL: assert property (
		host_wr_i && host_page_i && host_addr_i == 8'hAD &&
		!uc_wr_i |=> $stable(line_left_mix_level_o) &&
			$stable(path_mute_o[3]))
		else $error("right write disturbed left channel");

	// Read returns the byte standing at the read edge, so the level
	// and mute seen there must come back unchanged
	AST_READBACK: assert property (
		host_rd_i && host_page_i && host_addr_i == 8'hAE
		|=> host_rdata_o[4:0] == $past(amic_left_mix_level_o) &&
			host_rdata_o[7] == $past(path_mute_o[5]))
		else $error("readback differs from stored byte");

	AST_HOLE_READ: assert property (
		host_rd_i && host_page_i && host_addr_i == 8'hB2
		|=> host_rdata_o == 8'h00)
		else $error("unmapped read not zero");

	// Right amic channel and its decoded gain also start at their defaults
	AST_RESET_REST: assert property (
		$rose(resetn_i) |-> mix_gain_hdb_o[6] == 8'hF4 &&
			amic_right_mix_level_o == 5'h0C)
		else $error("mixer right gain not at default after reset");

	// Read data registers clear with the bank
	AST_RDATA_RESET: assert property (
		$rose(resetn_i) |-> host_rdata_o == 8'h00 &&
			uc_rdata_o == 8'h00)
		else $error("read data not cleared by reset");

	// Right capture stage starts at unity as well
	AST_CAP_RESET_R: assert property (
		$rose(resetn_i) |-> capture0_right_gain_level_o == 4'h0 &&
			capture0_gain_hdb_o[0] == 6'h00)
		else $error("right capture gain not zero after reset");

	// Decode of the first mixer path, bottom end of the index range
	AST_MIX_DECODE_D0: assert property (
		##1 mix_gain_hdb_o[0] ==
			8'(24 - 3 * int'(dac0_right_mix_level_o)))
		else $error("dac0 mixer gain decode wrong");

	// Decode of the second mixer path written by the controller
	AST_MIX_DECODE_D1: assert property (
		##1 mix_gain_hdb_o[1] ==
			8'(24 - 3 * int'(dac1_left_mix_level_o)))
		else $error("dac1 mixer gain decode wrong");

	// Right capture decode, same 1.5 dB ladder as the left
	AST_CAP_DECODE_R: assert property (
		##1 capture0_gain_hdb_o[1] ==
			6'(3 * int'(capture0_right_gain_level_o)))
		else $error("right capture gain decode wrong");

	// Mute bit of the lowest register follows a host write
	AST_MUTE_D0: assert property (
		host_wr_i && host_page_i && host_addr_i == 8'hA9 && !uc_wr_i
		|=> path_mute_o[0] == $past(host_wdata_i[7]))
		else $error("dac0 mute not taken from bit 7");

	// Mute bit of the last mixer register, even index
	AST_MUTE_AMIC_R: assert property (
		host_wr_i && host_page_i && host_addr_i == 8'hAF && !uc_wr_i
		|=> path_mute_o[6] == $past(host_wdata_i[7]))
		else $error("amic right mute not taken from bit 7");

	// Capture mute lands only on its path flag; the converter has no
	// input from this bank, so its stream cannot be stopped here
	AST_CAP_MUTE: assert property (
		uc_wr_i && uc_addr_i == 16'hA1B1 &&
		!(host_wr_i && host_page_i && host_addr_i == 8'hB1)
		|=> path_mute_o[8] == $past(uc_wdata_i[7]) &&
			$stable(path_mute_o[7]))
		else $error("capture mute not stored on its own path");

	// Left line write must leave the right line channel alone
	AST_OWN_LINE_R: assert property (
		host_wr_i && host_page_i && host_addr_i == 8'hAC &&
		!uc_wr_i |=> $stable(line_right_mix_level_o) &&
			$stable(path_mute_o[4]))
		else $error("left write disturbed right line channel");

	// Left dac1 write must leave the right dac1 channel alone
	AST_OWN_DAC1_R: assert property (
		host_wr_i && host_page_i && host_addr_i == 8'hAA &&
		!uc_wr_i |=> $stable(dac1_right_mix_level_o) &&
			$stable(path_mute_o[2]))
		else $error("left write disturbed right dac1 channel");

	// Right amic write must leave the left amic channel alone
	AST_OWN_AMIC_L: assert property (
		host_wr_i && host_page_i && host_addr_i == 8'hAF &&
		!uc_wr_i |=> $stable(amic_left_mix_level_o) &&
			$stable(path_mute_o[5]))
		else $error("right write disturbed left amic channel");

	// Page 0 belongs to other blocks; nothing here may move
	AST_PAGE0_REFUSED: assert property (
		host_wr_i && !host_page_i && !uc_wr_i
		|=> $stable(path_mute_o) && $stable(line_left_mix_level_o))
		else $error("page 0 write changed the bank");

	// Wrong high byte on the controller side is ignored
	AST_PREFIX_REFUSED: assert property (
		uc_wr_i && uc_addr_i[15:8] != 8'hA1 &&
		!(host_wr_i && host_page_i)
		|=> $stable(path_mute_o) && $stable(line_left_mix_level_o))
		else $error("foreign controller write changed the bank");

	// Controller readback of the left line register
	AST_UC_READ: assert property (
		uc_rd_i && uc_addr_i == 16'hA1AC
		|=> uc_rdata_o[4:0] == $past(line_left_mix_level_o) &&
			uc_rdata_o[7] == $past(path_mute_o[3]))
		else $error("controller read of A1AC wrong");

	// Controller hole read gives zero, never a stale byte
	AST_UC_HOLE: assert property (
		uc_rd_i && uc_addr_i == 16'hA1B2 |=> uc_rdata_o == 8'h00)
		else $error("controller unmapped read not zero");

	// Host read data holds between read strobes, so a slow slave
	// may fetch it any time later
	AST_HOST_RD_HOLD: assert property (
		!host_rd_i |=> $stable(host_rdata_o))
		else $error("host read data moved without a read");

	// Same hold on the controller side
	AST_UC_RD_HOLD: assert property (
		!uc_rd_i |=> $stable(uc_rdata_o))
		else $error("controller read data moved without a read");

endmodule

// ### amigr_ctl_model.sv
/* Controlling party: drives host and controller strobes of the bank.
   Assumes the bench gives mclk_i and samples read data itself. */
`timescale 1ns/1ps
module amigr_ctl_model (
	input wire logic mclk_i
);
	logic        host_page  = 1'b0;     // Page select
	logic [7:0]  host_addr  = 8'h00;    // Host offset
	logic [7:0]  host_wdata = 8'h00;    // Host write byte
	logic        host_wr    = 1'b0;     // Host strobes
	logic        host_rd    = 1'b0;
	logic [15:0] uc_addr    = 16'h0000; // Controller address
	logic [7:0]  uc_wdata   = 8'h00;    // Controller write byte
	logic        uc_wr      = 1'b0;     // Controller strobes
	logic        uc_rd      = 1'b0;
	// One-cycle access, a[8] is the host page; on release address and data invert
	// so a stale value never passes for a live request
	task automatic acc(input logic uc, input logic wr,
		input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		#1;
		if (uc) begin
			{uc_addr, uc_wdata, uc_wr, uc_rd} = {a, d, wr, !wr};
		end else begin
			{host_page, host_addr, host_wdata} = {a[8], a[7:0], d};
			{host_wr, host_rd} = {wr, !wr};
		end
		@(posedge mclk_i);
		#1;
		{host_wr, host_rd, uc_wr, uc_rd} = 4'h0;
		{host_addr, host_wdata, uc_addr, uc_wdata} =
			~{host_addr, host_wdata, uc_addr, uc_wdata};
	endtask
endmodule

// ### audio_mixer_input_gain_regs_bench.sv
/* Self-checking bench for the mixer input gain register bank.
   Assumes the package, the bank and the controller model exist. */
`timescale 1ns/1ps
module audio_mixer_input_gain_regs_bench;
	logic            mclk_i    = 1'b0; // 100 MHz clock
	logic            resetn_i  = 1'b0; // Synchronous reset
	logic [7:0]      hrd;              // Host read byte
	logic [7:0]      urd;              // Controller read byte
	logic [4:0]      lv [7];           // Mixer levels
	logic [3:0]      cv [2];           // Capture levels
	logic [8:0]      mute;             // Path mutes
	logic [6:0][7:0] mhdb;             // Mixer gains, half-dB
	logic [1:0][5:0] chdb;             // Capture gains, half-dB
	int              err_total = 0;    // Mismatches
	int              tests_run = 0;    // Comparisons
	wire logic [42:0] lvall = {lv[0], lv[1], lv[2], lv[3], lv[4], lv[5],
		lv[6], cv[0], cv[1]};
	amigr_ctl_model amigr_ctl_model_inst (.mclk_i(mclk_i));
	amigr_regs amigr_regs_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.host_page_i(amigr_ctl_model_inst.host_page),
		.host_addr_i(amigr_ctl_model_inst.host_addr),
		.host_wr_i(amigr_ctl_model_inst.host_wr),
		.host_rd_i(amigr_ctl_model_inst.host_rd),
		.host_wdata_i(amigr_ctl_model_inst.host_wdata),
		.host_rdata_o(hrd), .uc_addr_i(amigr_ctl_model_inst.uc_addr),
		.uc_wr_i(amigr_ctl_model_inst.uc_wr),
		.uc_rd_i(amigr_ctl_model_inst.uc_rd),
		.uc_wdata_i(amigr_ctl_model_inst.uc_wdata), .uc_rdata_o(urd),
		.dac0_right_mix_level_o(lv[0]), .dac1_left_mix_level_o(lv[1]),
		.dac1_right_mix_level_o(lv[2]), .line_left_mix_level_o(lv[3]),
		.line_right_mix_level_o(lv[4]), .amic_left_mix_level_o(lv[5]),
		.amic_right_mix_level_o(lv[6]),
		.capture0_left_gain_level_o(cv[0]),
		.capture0_right_gain_level_o(cv[1]), .path_mute_o(mute),
		.mix_gain_hdb_o(mhdb), .capture0_gain_hdb_o(chdb));
	// Compare and count
	task automatic chk(input string nm, input logic [63:0] e, g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Read through either port, compare with the expected byte
	task automatic rdchk(input logic uc, input logic [15:0] a,
		input logic [7:0] e);
		amigr_ctl_model_inst.acc(uc, 1'b0, a, 8'h00);
		chk("read byte", {56'h0, e}, {56'h0, uc ? urd : hrd});
	endtask
	// Distinct byte per register; reserved bits kept at zero
	function automatic logic [7:0] val(input int i);
		val = (i < 7) ? {i[0], 2'b00, 5'(3 * i + 4)}
			: {i[0], 3'b000, 4'(i + 5)};
	endfunction
	// Reset bytes, mutes and levels
	task automatic t_reset;
		for (int i = 0; i < 9; i++) begin
			rdchk(1'b0, 16'h01A9 + 16'(i), (i < 7) ? 8'h8C : 8'h80);
		end
		chk("mute", 64'h1FF, {55'h0, mute});
		chk("levels", {21'h0, {7{5'h0C}}, 8'h00}, {21'h0, lvall});
	endtask
	// Host writes all, each lands on its own channel only
	task automatic t_write;
		logic [42:0] el;
		logic [8:0]  em;
		logic [7:0]  v;
		for (int i = 0; i < 9; i++) begin
			v = val(i);
			amigr_ctl_model_inst.acc(1'b0, 1'b1, 16'h01A9 + 16'(i), v);
			el = (i < 7) ? {el[37:0], v[4:0]} : {el[38:0], v[3:0]};
			em[i] = v[7];
		end
		chk("levels", {21'h0, el}, {21'h0, lvall});
		chk("mute", {55'h0, em}, {55'h0, mute});
		for (int i = 0; i < 9; i++) begin
			rdchk(1'b1, 16'hA1A9 + 16'(i), val(i));
		end
	endtask
	// Page 0, wrong prefix and holes are refused
	task automatic t_refuse;
		amigr_ctl_model_inst.acc(1'b0, 1'b1, 16'h00AC, 8'h1F);
		amigr_ctl_model_inst.acc(1'b1, 1'b1, 16'hA2AC, 8'h1F);
		rdchk(1'b0, 16'h01AC, val(3));
		rdchk(1'b0, 16'h00AC, 8'h00);
		rdchk(1'b1, 16'hA1B2, 8'h00);
		rdchk(1'b0, 16'h01A8, 8'h00);
		rdchk(1'b0, 16'h01B2, 8'h00);
		rdchk(1'b0, 16'h01AE, val(5));
	endtask
	// Both end codes of the mixer gain, top capture code, capture mute
	task automatic t_decode;
		amigr_ctl_model_inst.acc(1'b1, 1'b1, 16'hA1AA, 8'h00);
		chk("top gain", 64'h18, {56'h0, mhdb[1]});
		amigr_ctl_model_inst.acc(1'b1, 1'b1, 16'hA1AA, 8'h1F);
		chk("floor gain", 64'hBB, {56'h0, mhdb[1]});
		amigr_ctl_model_inst.acc(1'b0, 1'b1, 16'h01B0, 8'h8F);
		chk("capture gain", 64'd45, {58'h0, chdb[0]});
		chk("capture mute", 64'h1, {63'h0, mute[7]});
		chk("capture level", 64'hF, {60'h0, cv[0]});
		amigr_ctl_model_inst.acc(1'b1, 1'b1, 16'hA1B1, 8'h0F);
		chk("right capture", 64'hF, {60'h0, cv[1]});
		chk("right gain", 64'd45, {58'h0, chdb[1]});
		chk("right unmute", 64'h0, {63'h0, mute[8]});
		chk("left mute kept", 64'h1, {63'h0, mute[7]});
	endtask
	// Verdict and end of run
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Clock
	initial begin
		forever #5 mclk_i = ~mclk_i;
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge mclk_i);
		#1;
		resetn_i = 1'b1;
		t_reset();
		t_write();
		t_refuse();
		t_decode();
		print_verdict();
	end
	// Watchdog, far above the roughly 80 cycles needed
	initial begin
		#20000;
		err_total++;
		print_verdict();
	end
endmodule
